// ===== verif/txi_mac_model.sv
// MAC-side request model: pushes one word per call and holds it until taken.
// Assumes the block registers req_ready and samples on rising edges.
`default_nettype none

module txi_mac_model (
    input  wire logic            clock,
    input  wire logic            req_ready,
    output txi_pkg::txi_req_type req_data,
    output logic                 req_valid
);
    timeunit 1ns;
    timeprecision 1ps;

    // Quiet request port at time zero
    initial begin
        req_valid = 1'b0;
        req_data = '0;
    end

    // Data inverts once released so a stale word is never taken by mistake
    task automatic send(input logic [4:0] sym, input logic delim, input logic par);
        @(posedge clock);
        req_valid <= 1'b1;
        req_data <= txi_pkg::txi_req_type'{sym, sym, delim, par};
        do @(posedge clock); while (req_ready !== 1'b1);
        req_valid <= 1'b0;
        req_data <= ~req_data;
    endtask : send
endmodule : txi_mac_model

`default_nettype wire

// ===== verif/txi_top_tb.sv
// Self-checking bench for the transmit symbol injection block.
// Assumes one clock at 25 MHz and the MAC model on the request port.
`default_nettype none

module txi_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic                 clock = 1'b0;
    logic                 arst_n = 1'b0;
    logic                 avs_read = 1'b0;
    logic                 avs_write = 1'b0;
    logic [5:0]           avs_address = 6'h00;
    logic [31:0]          avs_writedata = 32'h0;
    logic [31:0]          avs_readdata_r;
    logic                 avs_waitrequest_r;
    logic                 req_valid;
    logic                 req_ready;
    logic                 tx_strobe_r;
    logic                 optical_tx_enable_r;
    logic [9:0]           tx_pair_r;
    txi_pkg::txi_req_type req_data;
    int                   fails = 0;
    int                   num_checks = 0;

    always #20 clock = ~clock;

    txi_top #(.FIFO_DEPTH(16)) u_txi_top (.clock, .arst_n, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_byteenable(4'h1), .avs_readdata_r,
        .avs_waitrequest_r, .req_valid, .req_data, .req_ready, .tx_pair_r, .tx_strobe_r,
        .optical_tx_enable_r);
    txi_mac_model u_txi_mac_model (.clock, .req_ready, .req_data, .req_valid);

    // ------------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------------
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Request holds to the rising edge that samples waitrequest low; data is taken there
    task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        @(posedge clock);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= {24'h0, d};
        do @(posedge clock); while (avs_waitrequest_r !== 1'b0);
        q = avs_readdata_r[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic rd_chk(string what, input logic [5:0] a, input logic [7:0] exp);
        logic [7:0] q;
        bus(1'b0, a, 8'h00, q);
        check(what, {24'h0, q}, {24'h0, exp});
    endtask : rd_chk

    // Strobe is a one-cycle pulse, so it is looked at on every falling edge
    task automatic get_pair(output logic [9:0] p);
        int i;
        i = 0;
        do @(negedge clock); while (tx_strobe_r !== 1'b1 && ++i < 10);
        p = tx_pair_r;
    endtask : get_pair

    // ------------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------------
    task automatic test_reset;
        rd_chk("ctrl reset", 6'h10, 8'ha2);
        check("txe in off", {31'h0, optical_tx_enable_r}, 32'h0);
        rd_chk("unmapped", 6'h3c, 8'h00);
        rd_chk("sym first reset", 6'h18, 8'he0);
        $display("test reset done");
    endtask : test_reset

    // Idle pattern underneath, so any pair other than the injected one reads 3ff
    task automatic run_inj(input logic [7:0] ctrl, input logic [7:0] n, input int exp);
        logic [9:0] p;
        int         hits;
        int         idles;
        wr(6'h14, n);
        wr(6'h10, ctrl);
        repeat (2) get_pair(p);
        hits = 0;
        idles = 0;
        repeat (12) begin
            get_pair(p);
            hits += (p === 10'h155);
            idles += (p === 10'h3ff);
        end
        check("injected pairs", hits, exp);
        check("idle pairs", idles, 12 - exp);
        check("txe in idle", {31'h0, optical_tx_enable_r}, 32'h1);
        $display("test injection ctrl %h count %0d done", ctrl, n);
    endtask : run_inj

    // Fixed line patterns, then continuous injection on top of halt
    task automatic test_patterns;
        logic [9:0] p;
        logic [7:0] ctrl [5] = '{8'h84, 8'h85, 8'h86, 8'h87, 8'h9d};
        logic [9:0] exp  [5] = '{10'h080, 10'h084, 10'h000, 10'h000, 10'h155};
        for (int k = 0; k < 5; k++) begin
            wr(6'h10, ctrl[k]);
            repeat (2) get_pair(p);
            check("pattern pair", p, exp[k]);
        end
        $display("test patterns done");
    endtask : test_patterns

    // Sixteen words fill the FIFO while idle; parity is sent wrong on purpose
    task automatic run_oneshot(input logic [7:0] n, input logic pe);
        logic [9:0] p;
        int         got;
        int         i;
        wr(6'h20, 8'h01);
        wr(6'h14, n);
        wr(6'h10, 8'h81);
        for (int j = 1; j <= 16; j++) begin
            u_txi_mac_model.send(5'(j), j == 1, 1'b0);
        end
        repeat (2) @(negedge clock);
        check("fifo full", {31'h0, req_ready}, 32'h0);
        wr(6'h10, {1'b1, pe, 6'h08});
        got = 1;
        i = 0;
        while (got <= 16 && i < 60) begin
            get_pair(p);
            i++;
            if (p !== 10'h3ff) begin
                check("pair", p, got == n + 1 ? 10'h155 : {got[4:0], got[4:0]});
                got++;
            end
        end
        check("words seen", got, 17);
        rd_chk("ctrl after one-shot", 6'h10, {1'b1, pe, 6'h00});
        rd_chk("parity error", 6'h20, {7'h0, pe});
        $display("test one-shot count %0d done", n);
    endtask : run_oneshot

    task automatic final_report;
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : final_report

    // Whole run needs a few hundred cycles; this cuts a hang short
    initial begin
        repeat (20000) @(posedge clock);
        fails++;
        final_report();
    end

    // Main sequence
    initial begin
        repeat (12) @(posedge clock);
        arst_n <= 1'b1;
        test_reset();
        wr(6'h18, 8'h0a);
        wr(6'h1c, 8'h15);
        run_inj(8'h81, 8'h00, 0);
        run_inj(8'h91, 8'h00, 12);
        run_inj(8'h91, 8'h02, 4);
        run_inj(8'h91, 8'h03, 3);
        run_inj(8'h99, 8'h05, 12);
        test_patterns();
        run_oneshot(8'h02, 1'b0);
        run_oneshot(8'h00, 1'b1);
        final_report();
    end
endmodule : txi_top_tb

`default_nettype wire

// ===== verilog/txi_defines.svh
// Constants for the transmit symbol injection block: offsets, fields, resets, timing.
// Assumes inclusion by bare name from every file that needs them.
`ifndef TXI_DEFINES_SVH
`define TXI_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define TXI_IDX_STATE_CTRL   4'h4
`define TXI_IDX_THRESHOLD    4'h5
`define TXI_IDX_SYM_FIRST    4'h6
`define TXI_IDX_SYM_SECOND   4'h7
`define TXI_IDX_STATUS       4'h8
`define TXI_IDX_COUNT        4'h9

// ----------------------------------------------------------------------------
// Transmit state control and status fields
// ----------------------------------------------------------------------------
`define TXI_PAT_LSB          0
`define TXI_PAT_MSB          2
`define TXI_INJ_LOW_BIT      3
`define TXI_INJ_HIGH_BIT     4
`define TXI_SMOOTH_BIT       5
`define TXI_PARITY_EN_BIT    6
`define TXI_SPARE_BIT        7
`define TXI_STATUS_PERR_BIT  0
`define TXI_STATUS_BUSY_BIT  1

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define TXI_RST_STATE_CTRL   8'ha2
`define TXI_RST_THRESHOLD    8'h00
`define TXI_RST_SYM          8'he0
`define TXI_RST_COUNT        8'h00

// ----------------------------------------------------------------------------
// Fixed symbols and timing
// ----------------------------------------------------------------------------
`define TXI_SYM_IDLE         5'h1f
`define TXI_SYM_QUIET        5'h00
`define TXI_SYM_HALT         5'h04
`define TXI_CLK_PERIOD_NS    40
`define TXI_PAIR_TIME_NS     80
`define TXI_PAIR_CYCLES      (`TXI_PAIR_TIME_NS / `TXI_CLK_PERIOD_NS)

`endif

// ===== verilog/txi_fifo.sv
// Request FIFO with parameter width and depth, valid and ready on both sides.
// Assumes a single clock; depth is a power of two.
`default_nettype none

module txi_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 16
) (
    input  wire logic             clock,
    input  wire logic             arst_n,
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    output logic                  out_valid,
    output logic      [WIDTH-1:0] out_data,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    rd_ptr_r;
    logic [AW:0]      level_r;
    logic [AW:0]      level_nxt;
    wire              push = in_valid && in_ready;
    wire              pop  = out_ready && out_valid;

    // Ready and valid are flops themselves so neither side sees a glitch
    assign level_nxt = level_r + (AW+1)'(push) - (AW+1)'(pop);
    assign out_data  = mem[rd_ptr_r];

    // Storage write
    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_ptr_r] <= in_data;
        end
    end

    // Pointers and level
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            level_r   <= '0;
            in_ready  <= 1'b1;
            out_valid <= 1'b0;
        end else begin
            wr_ptr_r  <= wr_ptr_r + AW'(push);
            rd_ptr_r  <= rd_ptr_r + AW'(pop);
            level_r   <= level_nxt;
            in_ready  <= (level_nxt != (AW+1)'(DEPTH));
            out_valid <= (level_nxt != '0);
        end
    end

endmodule : txi_fifo

`default_nettype wire

// ===== verilog/txi_inj_counter.sv
// Eight-bit injection down-counter with reload.
// Assumes step is already gated by the pair-rate enable and the mode.
`include "txi_defines.svh"
`default_nettype none

module txi_inj_counter #(
    parameter int WIDTH = 8
) (
    input  wire logic             clock,
    input  wire logic             arst_n,
    input  wire logic             step,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] load_value,
    output logic      [WIDTH-1:0] count_r
);
    logic [WIDTH-1:0] count_nxt;

    // Load wins over step; zero reloads instead of wrapping
    assign count_nxt = load ? load_value :
                       !step ? count_r :
                       (count_r == '0) ? load_value : count_r - WIDTH'(1);

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            count_r <= WIDTH'(`TXI_RST_COUNT);
        end else begin
            count_r <= count_nxt;
        end
    end

endmodule : txi_inj_counter

`default_nettype wire

// ===== verilog/txi_pkg.sv
// Types shared by the transmit symbol injection block.
// Assumes nothing; compiled before all modules.
`default_nettype none

package txi_pkg;

    // ------------------------------------------------------------------------
    // Modes and states
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        TXI_INJ_NONE     = 2'h0,
        TXI_INJ_ONESHOT  = 2'h1,
        TXI_INJ_PERIODIC = 2'h2,
        TXI_INJ_CONT     = 2'h3
    } txi_inj_mode_type;

    typedef enum logic [2:0] {
        TXI_PAT_ACTIVE = 3'h0,
        TXI_PAT_IDLE   = 3'h1,
        TXI_PAT_OFF    = 3'h2,
        TXI_PAT_RSV3   = 3'h3,
        TXI_PAT_MASTER = 3'h4,
        TXI_PAT_HALT   = 3'h5,
        TXI_PAT_QUIET  = 3'h6,
        TXI_PAT_RSV7   = 3'h7
    } txi_pat_type;

    typedef enum logic [2:0] {
        TXI_OS_IDLE  = 3'h1,
        TXI_OS_WAIT  = 3'h2,
        TXI_OS_COUNT = 3'h4
    } txi_os_state_type;

    // ------------------------------------------------------------------------
    // Request word from the media access controller
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [4:0] first;
        logic [4:0] second;
        logic       start_delim;
        logic       parity;
    } txi_req_type;

endpackage : txi_pkg

`default_nettype wire

// ===== verilog/txi_top.sv
// Transmit symbol injection control: register file, pattern and injection muxing.
// Assumes Avalon-MM master on the register port and request words synchronous
// to clock; one symbol pair leaves every pair-rate enable.
//
// Decided for this implementation: the placing of the registers and the Avalon-MM register port.
`include "txi_defines.svh"
`default_nettype none

module txi_top #(
    parameter int FIFO_DEPTH = 16
) (
    input  wire logic                 clock,
    input  wire logic                 arst_n,
    input  wire logic [5:0]           avs_address,
    input  wire logic                 avs_read,
    input  wire logic                 avs_write,
    input  wire logic [31:0]          avs_writedata,
    input  wire logic [3:0]           avs_byteenable,
    output logic      [31:0]          avs_readdata_r,
    output logic                      avs_waitrequest_r,
    input  wire logic                 req_valid,
    input  wire txi_pkg::txi_req_type req_data,
    output logic                      req_ready,
    output logic      [9:0]           tx_pair_r,
    output logic                      tx_strobe_r,
    output logic                      optical_tx_enable_r
);
    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    logic [7:0]                 state_ctrl_r;
    logic [7:0]                 state_ctrl_nxt;
    logic [7:0]                 threshold_r;
    logic [7:0]                 sym_first_r;
    logic [7:0]                 sym_second_r;
    logic                       parity_err_r;
    logic                       tick_r;
    logic [1:0]                 div_r;
    logic [7:0]                 count_r;
    logic                       fifo_valid;
    txi_pkg::txi_req_type       head;
    txi_pkg::txi_os_state_type  os_state_r;
    txi_pkg::txi_os_state_type  os_state_nxt;
    logic [9:0]                 base_pair;
    logic [31:0]                rd_mux;

    // ------------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------------
    wire [3:0] reg_idx    = avs_address[5:2];
    wire       wr_fire    = avs_write && !avs_waitrequest_r && avs_byteenable[0];
    wire       rd_take    = avs_read && avs_waitrequest_r;
    wire       wr_ctrl    = wr_fire && (reg_idx == `TXI_IDX_STATE_CTRL);
    wire       wr_thr     = wr_fire && (reg_idx == `TXI_IDX_THRESHOLD);
    wire       wr_sym_a   = wr_fire && (reg_idx == `TXI_IDX_SYM_FIRST);
    wire       wr_sym_b   = wr_fire && (reg_idx == `TXI_IDX_SYM_SECOND);
    wire       wr_status  = wr_fire && (reg_idx == `TXI_IDX_STATUS);
    wire [7:0] wdata      = avs_writedata[7:0];

    // ------------------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------------------
    wire txi_pkg::txi_inj_mode_type inj_mode =
        txi_pkg::txi_inj_mode_type'(state_ctrl_r[`TXI_INJ_HIGH_BIT:`TXI_INJ_LOW_BIT]);
    wire txi_pkg::txi_pat_type pat =
        txi_pkg::txi_pat_type'(state_ctrl_r[`TXI_PAT_MSB:`TXI_PAT_LSB]);
    wire       mode_os    = (inj_mode == txi_pkg::TXI_INJ_ONESHOT);
    wire       mode_per   = (inj_mode == txi_pkg::TXI_INJ_PERIODIC);
    wire       mode_cont  = (inj_mode == txi_pkg::TXI_INJ_CONT);
    wire       parity_en  = state_ctrl_r[`TXI_PARITY_EN_BIT];
    wire [9:0] inj_pair   = {sym_first_r[4:0], sym_second_r[4:0]};

    // ------------------------------------------------------------------------
    // Data path and injection decision
    // ------------------------------------------------------------------------
    // Only the active pattern drains the FIFO; other patterns back-pressure the source
    wire       pat_active = (pat == txi_pkg::TXI_PAT_ACTIVE);
    wire       pop        = tick_r && pat_active && fifo_valid;
    wire       jk_now     = pop && head.start_delim;
    // Idle counts as waiting, so a delimiter in the first slot after arming is not missed
    wire       os_wait    = (os_state_r != txi_pkg::TXI_OS_COUNT);
    wire       os_count   = (os_state_r == txi_pkg::TXI_OS_COUNT);
    wire       thr_zero   = (threshold_r == 8'h00);
    wire       os_hit_jk  = mode_os && os_wait && jk_now && thr_zero;
    wire       os_hit_cnt = mode_os && os_count && (count_r == 8'h01);
    wire       per_hit    = mode_per && (count_r == 8'h00);
    wire       inject     = tick_r && (mode_cont || per_hit || os_hit_jk || os_hit_cnt);
    wire       os_done    = tick_r && (os_hit_jk || os_hit_cnt);
    wire       cnt_step   = tick_r && (mode_per || (mode_os && os_count));
    wire       cnt_load   = wr_thr || (tick_r && mode_os && os_wait && jk_now);
    wire       bad_parity = pop && parity_en && !(^{head.first, head.second, head.parity});
    wire       txe_nxt    = (pat != txi_pkg::TXI_PAT_OFF);

    // Line pattern per transmit pattern code; reserved codes fall to quiet
    always_comb begin
        case (pat)
            txi_pkg::TXI_PAT_ACTIVE: base_pair = fifo_valid ? {head.first, head.second}
                                                            : {`TXI_SYM_IDLE, `TXI_SYM_IDLE};
            txi_pkg::TXI_PAT_IDLE:   base_pair = {`TXI_SYM_IDLE, `TXI_SYM_IDLE};
            txi_pkg::TXI_PAT_MASTER: base_pair = {`TXI_SYM_HALT, `TXI_SYM_QUIET};
            txi_pkg::TXI_PAT_HALT:   base_pair = {`TXI_SYM_HALT, `TXI_SYM_HALT};
            default:                 base_pair = {`TXI_SYM_QUIET, `TXI_SYM_QUIET};
        endcase
    end

    // One-shot sequencer: wait for a delimiter, then count pairs
    always_comb begin
        case (os_state_r)
            txi_pkg::TXI_OS_IDLE,
            txi_pkg::TXI_OS_WAIT:  os_state_nxt = !mode_os ? txi_pkg::TXI_OS_IDLE :
                                                  os_done ? txi_pkg::TXI_OS_IDLE :
                                                  (tick_r && jk_now) ? txi_pkg::TXI_OS_COUNT :
                                                  txi_pkg::TXI_OS_WAIT;
            txi_pkg::TXI_OS_COUNT: os_state_nxt = (!mode_os || os_done) ? txi_pkg::TXI_OS_IDLE
                                                                        : txi_pkg::TXI_OS_COUNT;
            default:               os_state_nxt = txi_pkg::TXI_OS_IDLE;
        endcase
    end

    // Software write wins over the hardware clear so a new arm is never lost
    assign state_ctrl_nxt = wr_ctrl ? wdata :
        (os_done ? (state_ctrl_r & ~(8'h01 << `TXI_INJ_LOW_BIT)) : state_ctrl_r);

    // Read mux; unmapped words read zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (reg_idx)
            `TXI_IDX_STATE_CTRL: rd_mux[7:0] = state_ctrl_r;
            `TXI_IDX_THRESHOLD:  rd_mux[7:0] = threshold_r;
            `TXI_IDX_SYM_FIRST:  rd_mux[7:0] = sym_first_r;
            `TXI_IDX_SYM_SECOND: rd_mux[7:0] = sym_second_r;
            `TXI_IDX_STATUS:     rd_mux[1:0] = {!(os_state_r == txi_pkg::TXI_OS_IDLE),
                                                parity_err_r};
            `TXI_IDX_COUNT:      rd_mux[7:0] = count_r;
            default:             rd_mux = 32'h0000_0000;
        endcase
    end

    // ------------------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------------------
    txi_fifo #(
        .WIDTH ($bits(txi_pkg::txi_req_type)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clock     (clock),
        .arst_n    (arst_n),
        .in_valid  (req_valid),
        .in_data   (req_data),
        .in_ready  (req_ready),
        .out_valid (fifo_valid),
        .out_data  (head),
        .out_ready (pop)
    );

    txi_inj_counter #(
        .WIDTH (8)
    ) u_counter (
        .clock      (clock),
        .arst_n     (arst_n),
        .step       (cnt_step),
        .load       (cnt_load),
        .load_value (threshold_r),
        .count_r    (count_r)
    );

    // ------------------------------------------------------------------------
    // Pair-rate divider
    // ------------------------------------------------------------------------
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            div_r  <= 2'h0;
            tick_r <= 1'b0;
        end else begin
            div_r  <= (div_r == 2'(`TXI_PAIR_CYCLES - 1)) ? 2'h0 : div_r + 2'h1;
            tick_r <= (div_r == 2'(`TXI_PAIR_CYCLES - 1));
        end
    end

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_ctrl_r <= `TXI_RST_STATE_CTRL;
            threshold_r  <= `TXI_RST_THRESHOLD;
            sym_first_r  <= `TXI_RST_SYM;
            sym_second_r <= `TXI_RST_SYM;
            parity_err_r <= 1'b0;
            os_state_r   <= txi_pkg::TXI_OS_IDLE;
        end else begin
            state_ctrl_r <= state_ctrl_nxt;
            threshold_r  <= wr_thr ? wdata : threshold_r;
            sym_first_r  <= wr_sym_a ? wdata : sym_first_r;
            sym_second_r <= wr_sym_b ? wdata : sym_second_r;
            // New error wins over a write-one clear in the same cycle
            parity_err_r <= bad_parity ||
                            (parity_err_r && !(wr_status && wdata[`TXI_STATUS_PERR_BIT]));
            os_state_r   <= os_state_nxt;
        end
    end

    // Bus answer: one wait state for reads and writes
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            avs_waitrequest_r <= 1'b1;
            avs_readdata_r    <= 32'h0000_0000;
        end else begin
            avs_waitrequest_r <= !((avs_read || avs_write) && avs_waitrequest_r);
            avs_readdata_r    <= rd_take ? rd_mux : avs_readdata_r;
        end
    end

    // Line output, updated once per pair slot
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            tx_pair_r           <= {`TXI_SYM_QUIET, `TXI_SYM_QUIET};
            tx_strobe_r         <= 1'b0;
            optical_tx_enable_r <= 1'b0;
        end else begin
            tx_strobe_r <= tick_r;
            if (tick_r) begin
                tx_pair_r           <= inject ? inj_pair : base_pair;
                optical_tx_enable_r <= txe_nxt;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    a_pass_through: assert property (tick_r && inj_mode == txi_pkg::TXI_INJ_NONE && pop
        |=> tx_pair_r == $past({head.first, head.second}))
        else $error("data not passed unchanged");
    a_cont_override: assert property (tick_r && mode_cont && pat == txi_pkg::TXI_PAT_HALT
        |=> tx_pair_r == $past(inj_pair))
        else $error("injection lost to pattern");
    a_oneshot_nth: assert property (tick_r && mode_os && os_count && count_r == 8'h01
        |=> tx_pair_r == $past(inj_pair) && !os_count)
        else $error("one-shot not at nth pair");
    a_oneshot_jk: assert property (tick_r && mode_os && os_wait && jk_now && thr_zero
        |=> tx_pair_r == $past(inj_pair))
        else $error("delimiter pair not replaced");
    a_ic0_clear: assert property (os_done && !wr_ctrl
        |=> !state_ctrl_r[`TXI_INJ_LOW_BIT] && $stable(state_ctrl_r[7:4]))
        else $error("low mode bit not cleared alone");
    a_period_gap: assert property (tick_r && mode_per && count_r == 8'h00 && !wr_thr
        |=> count_r == $past(threshold_r))
        else $error("periodic reload wrong");
    a_periodic_all: assert property (tick_r && mode_per && thr_zero && count_r == 8'h00
        |=> tx_pair_r == $past(inj_pair))
        else $error("periodic zero missed a pair");
    a_cont_every: assert property (tick_r && mode_cont
        |=> tx_pair_r == $past(inj_pair) ##1 tx_strobe_r == 1'b0)
        else $error("continuous missed a pair");
    a_parity_flag: assert property (bad_parity |=> parity_err_r)
        else $error("parity error not flagged");
    a_parity_off: assert property (!parity_en && !parity_err_r |=> !parity_err_r)
        else $error("parity flagged while disabled");
    a_off_pattern: assert property (tick_r && pat == txi_pkg::TXI_PAT_OFF && !inject
        |=> !optical_tx_enable_r && tx_pair_r == 10'h000)
        else $error("off pattern wrong");
    a_step_rate: assert property (tick_r |=> !tick_r ##1 tick_r)
        else $error("counter step not every 80 ns");
    a_count_held: assert property (!mode_os && !mode_per && !wr_thr |=> $stable(count_r))
        else $error("counter ran outside its modes");

    c_oneshot_done: cover property (os_done ##1 !state_ctrl_r[`TXI_INJ_LOW_BIT]);
    c_periodic_hit: cover property (tick_r && per_hit && !thr_zero);
    c_parity_err:   cover property (bad_parity);
    c_fifo_full:    cover property (!req_ready);

endmodule : txi_top

`default_nettype wire
